// File: hw/clock_gen_cfg.svh
// constants of the clock generator register block: offsets, field
// positions, reset values and settle/divide counts.
// assumes an apb slave with 32-bit data, one register per aligned word.
`ifndef CLOCK_GEN_CFG_SVH
`define CLOCK_GEN_CFG_SVH

// register indices; byte address is four times the index
`define IDX_DISP_TCLK       30'h00005070
`define IDX_SETTLE_WAIT     30'h0000507d
`define IDX_PERIPH_GATE     30'h00005080
`define IDX_CPU_GEAR        30'h00005081

// display timing clock select fields
`define TCLK_DIV_HI         5
`define TCLK_DIV_LO         4
`define TCLK_SRC_HI         3
`define TCLK_SRC_LO         2
`define TCLK_EN_BIT         0
`define TCLK_DIV_RST        2'h0
`define TCLK_SRC_RST        2'h0
`define TCLK_EN_RST         1'h0

// settle wait fields
`define WAIT_FAST_HI        7
`define WAIT_FAST_LO        6
`define WAIT_SLOW_HI        1
`define WAIT_SLOW_LO        0
`define WAIT_FAST_RST       2'h0
`define WAIT_SLOW_RST       2'h0

// peripheral gate and cpu gear
`define PCLK_RST            2'h3
`define PCLK_ON             2'h3
`define PCLK_OFF            2'h0
`define CPU_CORE_CLOCK_RST            2'h0

// source codes
`define SRC_FAST            2'h0
`define SRC_SLOW            2'h1

// settle counts in oscillator cycles
`define FAST_WAIT_3         15'h0008
`define FAST_WAIT_2         15'h0010
`define FAST_WAIT_1         15'h0020
`define FAST_WAIT_0         15'h0040
`define SLOW_WAIT_2         15'h1000
`define SLOW_CODE_SHORT     2'h2

// display divide ratios in source cycles
`define FAST_DIV_0          14'h0400
`define FAST_DIV_1          14'h0800
`define FAST_DIV_2          14'h1000
`define SLOW_DIV            14'h0040

`endif

// File: hw/clock_gen_pkg.sv
// types shared by the clock generator register block.
// assumes clock_gen_cfg.svh supplies every number but SLOW_WAIT_0 and FAST_DIV_3, which are parameters.
package clock_gen_pkg;

   typedef enum logic [1:0] {
      SETTLE_OFF,
      SETTLE_COUNT,
      SETTLE_DONE
   } settle_state_type;

   typedef struct packed {
      logic [1:0] div;
      logic [1:0] src;
      logic       en;
   } disp_tclk_type;

   typedef struct packed {
      logic [1:0] fast;
      logic [1:0] slow;
   } settle_sel_type;

endpackage : clock_gen_pkg

// File: hw/osc_settle_wait.sv
// counts oscillator cycles after start and flags the clock usable.
// assumes oscTick is a one-cycle pulse per oscillator cycle on clk.
`timescale 1ns/1ps
`default_nettype none
module osc_settle_wait #(
   parameter int CNT_W = 15
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             oscOn,
   input  wire logic             oscTick,
   input  wire logic [CNT_W-1:0] waitCycles,
   output var  logic             ready
);
   clock_gen_pkg::settle_state_type stateReg;
   logic [CNT_W-1:0] countReg;
   logic [CNT_W-1:0] limitReg;

   // count latched at start so a mid-wait rewrite cannot shorten it
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stateReg <= clock_gen_pkg::SETTLE_OFF;
         countReg <= '0;
         limitReg <= '0;
      end else if (!oscOn) begin
         stateReg <= clock_gen_pkg::SETTLE_OFF;
         countReg <= '0;
      end else begin
         unique case (stateReg)
            clock_gen_pkg::SETTLE_OFF: begin
               stateReg <= clock_gen_pkg::SETTLE_COUNT;
               limitReg <= waitCycles;
               countReg <= '0;
            end
            clock_gen_pkg::SETTLE_COUNT: begin
               if (oscTick) begin
                  if (countReg == limitReg - 1'b1) begin
                     stateReg <= clock_gen_pkg::SETTLE_DONE;
                  end
                  countReg <= countReg + 1'b1;
               end
            end
            clock_gen_pkg::SETTLE_DONE: begin
               stateReg <= clock_gen_pkg::SETTLE_DONE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ready <= 1'b0;
      end else begin
         ready <= oscOn && (stateReg == clock_gen_pkg::SETTLE_DONE);
      end
   end
endmodule : osc_settle_wait
`default_nettype wire

// File: hw/disp_timing_div.sv
// divides a source tick stream down to the display timing tick.
// assumes srcTick is a one-cycle enable pulse per source cycle.
`timescale 1ns/1ps
`default_nettype none
module disp_timing_div #(
   parameter int DIV_W = 14
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             enable,
   input  wire logic             srcTick,
   input  wire logic [DIV_W-1:0] ratio,
   output var  logic             tick
);
   logic [DIV_W-1:0] countReg;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         countReg <= '0;
         tick     <= 1'b0;
      end else if (!enable) begin
         countReg <= '0;
         tick     <= 1'b0;
      end else if (srcTick) begin
         // a ratio change applies at once; a count already past a smaller ratio wraps at the next tick
         if (countReg >= ratio - 1'b1) begin
            countReg <= '0;
            tick     <= 1'b1;
         end else begin
            countReg <= countReg + 1'b1;
            tick     <= 1'b0;
         end
      end else begin
         tick <= 1'b0;
      end
   end
endmodule : disp_timing_div
`default_nettype wire

// File: hw/clock_gen_regs.sv
// clock generator registers: oscillator settle waits, peripheral clock
// gate, cpu gear select and the display timing clock select, over apb.
// assumes oscillator cycles arrive as one-cycle tick pulses on clk and
// oscillator start/stop levels come from elsewhere.
//
// Function
// - fast oscillator waits 8, 16, 32 or 64 cycles for codes 3 to 0, reset 0.
// - slow oscillator waits 4096 cycles for code 2, 16384 for code 0, reset 0.
// - peripheral supply is on for code 3, off for 0, reset 3, 1 and 2 banned.
// - a 2-bit cpu gear select sits in the low bits, reset 0, rest reserved.
// - every reserved bit reads back as zero.
// - display source is fast osc for code 0, slow for 1, reset 0, 2/3 banned.
// - display divide is 1024..8192 from fast osc, 64 from slow osc, reset 0.
// - one enable bit gates the display timing clock, reset disabled.
`include "clock_gen_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module clock_gen_regs #(
   parameter int SLOW_WAIT_0 = 16384,
   parameter int FAST_DIV_3  = 8192
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        fastOscOn,
   input  wire logic        fastOscTick,
   input  wire logic        slowOscOn,
   input  wire logic        slowOscTick,
   output var  logic        fastOscReady,
   output var  logic        slowOscReady,
   output var  logic        periphClockEn,
   output var  logic [1:0]  cpuGearRatio,
   output var  logic        dispTimingTick
);
   localparam logic [31:0] ADDR_TCLK = {`IDX_DISP_TCLK, 2'b00};
   localparam logic [31:0] ADDR_WAIT = {`IDX_SETTLE_WAIT, 2'b00};
   localparam logic [31:0] ADDR_PCLK = {`IDX_PERIPH_GATE, 2'b00};
   localparam logic [31:0] ADDR_CPU_CORE_CLOCK = {`IDX_CPU_GEAR, 2'b00};
   localparam logic [14:0] SLOW_LONG = 15'(SLOW_WAIT_0);
   localparam logic [13:0] FAST_DIV_MAX = 14'(FAST_DIV_3);

   clock_gen_pkg::disp_tclk_type  tclkReg;
   clock_gen_pkg::settle_sel_type waitReg;
   logic [1:0]  pclkReg;
   logic [1:0]  cclkReg;

   logic        accessPhase;
   logic        writeStrobe;
   logic        hitTclk;
   logic        hitWait;
   logic        hitPclk;
   logic        hitCclk;
   logic        hitAny;
   logic [7:0]  readByte;
   logic [14:0] fastWaitCycles;
   logic [14:0] slowWaitCycles;
   logic [13:0] dispRatio;
   logic        dispSrcTick;
   logic        dispSrcReady;
   logic        fastReadyInt;
   logic        slowReadyInt;
   logic        dispTickInt;

   // ---- apb slave: one wait state, write lands on the completing edge
   assign accessPhase = psel && penable;
   assign writeStrobe = accessPhase && pready && pwrite;

   assign hitTclk = (paddr == ADDR_TCLK);
   assign hitWait = (paddr == ADDR_WAIT);
   assign hitPclk = (paddr == ADDR_PCLK);
   assign hitCclk = (paddr == ADDR_CPU_CORE_CLOCK);
   assign hitAny  = hitTclk || hitWait || hitPclk || hitCclk;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pready <= 1'b0;
      end else if (accessPhase && !pready) begin
         pready <= 1'b1;
      end else begin
         pready <= 1'b0;
      end
   end

   // reserved positions stay zero by construction
   always_comb begin
      readByte = 8'h00;
      if (hitTclk) begin
         readByte[`TCLK_DIV_HI:`TCLK_DIV_LO] = tclkReg.div;
         readByte[`TCLK_SRC_HI:`TCLK_SRC_LO] = tclkReg.src;
         readByte[`TCLK_EN_BIT]              = tclkReg.en;
      end else if (hitWait) begin
         readByte[`WAIT_FAST_HI:`WAIT_FAST_LO] = waitReg.fast;
         readByte[`WAIT_SLOW_HI:`WAIT_SLOW_LO] = waitReg.slow;
      end else if (hitPclk) begin
         readByte[1:0] = pclkReg;
      end else if (hitCclk) begin
         readByte[1:0] = cclkReg;
      end
   end

   // read data and error are registered on the same edge that raises pready
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (accessPhase && !pready) begin
         prdata  <= pwrite ? 32'h00000000 : {24'h000000, readByte};
         pslverr <= !hitAny;
      end else begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
   end

   // ---- register writes, one process per register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tclkReg.div <= `TCLK_DIV_RST;
         tclkReg.src <= `TCLK_SRC_RST;
         tclkReg.en  <= `TCLK_EN_RST;
      end else if (writeStrobe && hitTclk) begin
         tclkReg.div <= pwdata[`TCLK_DIV_HI:`TCLK_DIV_LO];
         tclkReg.src <= pwdata[`TCLK_SRC_HI:`TCLK_SRC_LO];
         tclkReg.en  <= pwdata[`TCLK_EN_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         waitReg.fast <= `WAIT_FAST_RST;
         waitReg.slow <= `WAIT_SLOW_RST;
      end else if (writeStrobe && hitWait) begin
         waitReg.fast <= pwdata[`WAIT_FAST_HI:`WAIT_FAST_LO];
         waitReg.slow <= pwdata[`WAIT_SLOW_HI:`WAIT_SLOW_LO];
      end
   end

   // banned codes are dropped so the gate never sits half open
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pclkReg <= `PCLK_RST;
      end else if (writeStrobe && hitPclk) begin
         if (pwdata[1:0] == `PCLK_ON || pwdata[1:0] == `PCLK_OFF) begin
            pclkReg <= pwdata[1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cclkReg <= `CPU_CORE_CLOCK_RST;
      end else if (writeStrobe && hitCclk) begin
         cclkReg <= pwdata[1:0];
      end
   end

   // ---- settle counts per code
   always_comb begin
      unique case (waitReg.fast)
         2'h3: fastWaitCycles = `FAST_WAIT_3;
         2'h2: fastWaitCycles = `FAST_WAIT_2;
         2'h1: fastWaitCycles = `FAST_WAIT_1;
         2'h0: fastWaitCycles = `FAST_WAIT_0;
      endcase
   end

   // reserved slow codes fall back to the long wait, the safe side
   always_comb begin
      if (waitReg.slow == `SLOW_CODE_SHORT) begin
         slowWaitCycles = `SLOW_WAIT_2;
      end else begin
         slowWaitCycles = SLOW_LONG;
      end
   end

   osc_settle_wait #(
      .CNT_W (15)
   ) fastSettle (
      .clk        (clk),
      .reset_n    (reset_n),
      .oscOn      (fastOscOn),
      .oscTick    (fastOscTick),
      .waitCycles (fastWaitCycles),
      .ready      (fastReadyInt)
   );

   osc_settle_wait #(
      .CNT_W (15)
   ) slowSettle (
      .clk        (clk),
      .reset_n    (reset_n),
      .oscOn      (slowOscOn),
      .oscTick    (slowOscTick),
      .waitCycles (slowWaitCycles),
      .ready      (slowReadyInt)
   );

   // ---- display timing clock: source, ratio, gate
   always_comb begin
      if (tclkReg.src == `SRC_SLOW) begin
         dispRatio = `SLOW_DIV;
      end else begin
         unique case (tclkReg.div)
            2'h3: dispRatio = FAST_DIV_MAX;
            2'h2: dispRatio = `FAST_DIV_2;
            2'h1: dispRatio = `FAST_DIV_1;
            2'h0: dispRatio = `FAST_DIV_0;
         endcase
      end
   end

   // unsettled oscillators and reserved source codes feed no ticks
   always_comb begin
      if (tclkReg.src == `SRC_FAST) begin
         dispSrcTick  = fastOscTick && fastReadyInt;
         dispSrcReady = fastReadyInt;
      end else if (tclkReg.src == `SRC_SLOW) begin
         dispSrcTick  = slowOscTick && slowReadyInt;
         dispSrcReady = slowReadyInt;
      end else begin
         dispSrcTick  = 1'b0;
         dispSrcReady = 1'b0;
      end
   end

   disp_timing_div #(
      .DIV_W (14)
   ) dispDiv (
      .clk     (clk),
      .reset_n (reset_n),
      .enable  (tclkReg.en && dispSrcReady),
      .srcTick (dispSrcTick),
      .ratio   (dispRatio),
      .tick    (dispTickInt)
   );

   // ---- outputs, each from its own flop
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fastOscReady <= 1'b0;
         slowOscReady <= 1'b0;
      end else begin
         fastOscReady <= fastReadyInt;
         slowOscReady <= slowReadyInt;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         periphClockEn <= 1'b1;
      end else begin
         periphClockEn <= (pclkReg == `PCLK_ON);
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cpuGearRatio <= `CPU_CORE_CLOCK_RST;
      end else begin
         cpuGearRatio <= cclkReg;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         dispTimingTick <= 1'b0;
      end else begin
         dispTimingTick <= dispTickInt && tclkReg.en;
      end
   end
endmodule : clock_gen_regs
`default_nettype wire

// File: test/clock_gen_regs_assertions.sv
// checker of the clock generator block, watching its top ports.
// assumes the master holds paddr and pwdata while pready is high.
`include "clock_gen_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module clock_gen_regs_assertions #(
   parameter int SLOW_WAIT_0 = 16384,
   parameter int FAST_DIV_3  = 8192
) (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        fastOscOn,
   input wire logic        fastOscTick,
   input wire logic        fastOscReady,
   input wire logic        periphClockEn,
   input wire logic [1:0]  cpuGearRatio
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic [1:0]       fastCode_reg;
   logic             onDly_reg;
   logic             eligD1_reg;
   logic             eligD2_reg;
   logic [6:0]       tickCnt_reg;
   wire logic [29:0] idx = paddr[31:2];
   wire logic        acc = psel && penable && pready && pwrite;
   function automatic logic [7:0] live(input logic [29:0] i);
      case (i)
         `IDX_DISP_TCLK:   live = 8'h3d;
         `IDX_SETTLE_WAIT: live = 8'hc3;
         `IDX_PERIPH_GATE, `IDX_CPU_GEAR: live = 8'h03;
         default:          live = 8'h00;
      endcase
   endfunction : live
   always_ff @(posedge clk) begin
      if (!reset_n) fastCode_reg <= `WAIT_FAST_RST;
      else if (acc && idx == `IDX_SETTLE_WAIT) fastCode_reg <= pwdata[7:6];
   end
   // first running cycle not counted: the code is latched there;
   // ready rises two edges after the closing tick, so ticks count late
   always_ff @(posedge clk) begin
      onDly_reg <= reset_n && fastOscOn;
      if (!reset_n || !fastOscOn) begin
         tickCnt_reg <= 7'h00;
         eligD1_reg  <= 1'b0;
         eligD2_reg  <= 1'b0;
      end else begin
         eligD1_reg <= onDly_reg && fastOscTick;
         eligD2_reg <= eligD1_reg;
         if (eligD2_reg && !fastOscReady) begin
            tickCnt_reg <= tickCnt_reg + 7'h01;
         end
      end
   end
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held past one cycle");
   chk_answer_code: assert property (psel && penable && !pready |=>
      pready && pslverr == (live($past(idx)) == 8'h00))
      else $error("access answer or error flag wrong");
   chk_reserved_zero: assert property (
      pready |-> (prdata & ~{24'h0, live(idx)}) == 32'h0)
      else $error("reserved read bits not zero");
   chk_periph_follow: assert property (
      acc && idx == `IDX_PERIPH_GATE && !(pwdata[1] ^ pwdata[0]) |->
      ##2 periphClockEn == $past(pwdata[0], 2))
      else $error("supply did not follow write");
   chk_periph_banned: assert property (
      acc && idx == `IDX_PERIPH_GATE && (pwdata[1] ^ pwdata[0]) |=>
      $stable(periphClockEn) [*2])
      else $error("banned supply code took effect");
   chk_gear_follow: assert property (
      acc && idx == `IDX_CPU_GEAR |->
      ##2 cpuGearRatio == $past(pwdata[1:0], 2))
      else $error("gear select did not follow write");
   chk_fast_settle: assert property (
      $rose(fastOscReady) |->
      tickCnt_reg == (7'h08 << (2'h3 - fastCode_reg)))
      else $error("fast settle count wrong");
   chk_fast_off: assert property (!fastOscOn |-> ##2 !fastOscReady)
      else $error("fast ready stayed after stop");
   cov_banned: cover property (acc && (pwdata[1] ^ pwdata[0]));
   cov_error: cover property (pready && pslverr);
   cov_settle: cover property ($rose(fastOscReady));
endmodule : clock_gen_regs_assertions
bind clock_gen_regs clock_gen_regs_assertions #(
   .SLOW_WAIT_0(SLOW_WAIT_0), .FAST_DIV_3(FAST_DIV_3)
) chk (
   .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .fastOscOn(fastOscOn),
   .fastOscTick(fastOscTick), .fastOscReady(fastOscReady),
   .periphClockEn(periphClockEn), .cpuGearRatio(cpuGearRatio)
);
`default_nettype wire

// File: test/clock_gen_regs_tb_top.sv
// bench for the clock generator register block over apb.
// assumes oscillator ticks every second cycle while running.
`include "clock_gen_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, g) begin compares++; if ((g) !== (x)) begin fails++; \
 $display("ERROR %s expected %0h seen %0h", n, x, g); end end
module clock_gen_regs_tb_top;
   localparam int SLOW0 = 40;
   localparam int DIV3  = 20;
   logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, fastOscOn = 1'b0, slowOscOn = 1'b0;
   logic        fastOscTick = 1'b0, slowOscTick = 1'b0, phase = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
   logic        pready, pslverr, e, fastOscReady, slowOscReady;
   logic        periphClockEn, dispTimingTick;
   logic [1:0]  cpuGearRatio;
   logic [7:0]  v;
   int          fails = 0;
   int          compares = 0;
   int          fastDiv [4] = '{1024, 2048, 4096, DIV3};
   always #4 clk = ~clk;
   always @(posedge clk) begin
      phase <= ~phase;
      fastOscTick <= phase & fastOscOn;
      slowOscTick <= phase & slowOscOn;
   end
   clock_gen_regs #(.SLOW_WAIT_0(SLOW0), .FAST_DIV_3(DIV3)) dut (
      .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fastOscOn(fastOscOn),
      .fastOscTick(fastOscTick), .slowOscOn(slowOscOn),
      .slowOscTick(slowOscTick), .fastOscReady(fastOscReady),
      .slowOscReady(slowOscReady), .periphClockEn(periphClockEn),
      .cpuGearRatio(cpuGearRatio), .dispTimingTick(dispTimingTick));
   task automatic conclude();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   task automatic apb(input logic w, input logic [29:0] i,
                      input logic [31:0] d);
      int t;
      t = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      q = prdata;
      e = pslverr;
      `CHK("pready", 1'b1, pready)
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wrchk(input logic [29:0] i, input logic [31:0] d,
                        input logic [7:0] x);
      if (d[31]) apb(1'b1, i, d);
      apb(1'b0, i, 32'h0);
      `CHK("read data", {24'h0, x}, q)
   endtask : wrchk
   // ticks of the first running cycle are skipped, as the design does;
   // ready shows two edges after the closing tick, so ticks count late
   task automatic settle(input logic f, input int n);
      int   cnt;
      int   t;
      logic r;
      logic h1;
      logic h2;
      cnt = 0;
      t = 0;
      h1 = 1'b0;
      h2 = 1'b0;
      if (f) fastOscOn <= 1'b1;
      else slowOscOn <= 1'b1;
      @(posedge clk);
      do begin
         @(posedge clk);
         t++;
         r = f ? fastOscReady : slowOscReady;
         if (r !== 1'b1 && h2) cnt++;
         h2 = h1;
         h1 = f ? fastOscTick : slowOscTick;
      end while (r !== 1'b1 && t < 20000);
      `CHK("settle ticks", n, cnt)
   endtask : settle
   task automatic period(input int n);
      int cnt;
      int t;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (dispTimingTick !== 1'b1 && t < 20000);
      cnt = fastOscTick ? 1 : 0;
      do begin
         @(posedge clk);
         t++;
         if (dispTimingTick !== 1'b1 && fastOscTick) cnt++;
      end while (dispTimingTick !== 1'b1 && t < 40000);
      `CHK("display period", n, cnt)
   endtask : period
   task automatic quiet();
      int cnt;
      cnt = 0;
      repeat (4) @(posedge clk);
      repeat (200) begin
         @(posedge clk);
         if (dispTimingTick === 1'b1) cnt++;
      end
      `CHK("display ticks", 0, cnt)
   endtask : quiet
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      conclude();
   end
   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      `CHK("supply pin", 1'b1, periphClockEn)
      `CHK("gear pin", 2'h0, cpuGearRatio)
      wrchk(`IDX_DISP_TCLK, 32'h0, 8'h00);
      wrchk(`IDX_SETTLE_WAIT, 32'h0, 8'h00);
      wrchk(`IDX_PERIPH_GATE, 32'h0, 8'h03);
      wrchk(`IDX_CPU_GEAR, 32'h0, 8'h00);
      apb(1'b1, 30'h00005071, 32'hff);
      wrchk(30'h00005071, 32'h0, 8'h00);
      `CHK("unmapped error", 1'b1, e)
      for (int c = 0; c < 4; c++) begin
         v = {6'h3f, 2'(c)};
         wrchk(`IDX_CPU_GEAR, {24'hffffff, v}, v & 8'h03);
         `CHK("gear pin", 2'(c), cpuGearRatio)
      end
      wrchk(`IDX_PERIPH_GATE, 32'hfffffffc, 8'h00);
      `CHK("supply pin", 1'b0, periphClockEn)
      wrchk(`IDX_PERIPH_GATE, 32'h80000001, 8'h00);
      wrchk(`IDX_PERIPH_GATE, 32'h80000003, 8'h03);
      wrchk(`IDX_PERIPH_GATE, 32'h80000002, 8'h03);
      `CHK("supply pin", 1'b1, periphClockEn)
      for (int c = 3; c >= 0; c--) begin
         v = {2'(c), 6'h3e};
         wrchk(`IDX_SETTLE_WAIT, {24'hffffff, v}, v & 8'hc3);
         settle(1'b1, 8 << (3 - c));
         fastOscOn <= 1'b0;
         repeat (3) @(posedge clk);
         `CHK("fast ready", 1'b0, fastOscReady)
      end
      settle(1'b0, 4096);
      slowOscOn <= 1'b0;
      wrchk(`IDX_SETTLE_WAIT, 32'h800000c0, 8'hc0);
      `CHK("slow ready", 1'b0, slowOscReady)
      settle(1'b0, SLOW0);
      settle(1'b1, 8);
      for (int s = 0; s < 2; s++) begin
         for (int d = 0; d < 4; d++) begin
            v = {2'h3, 2'(d), 2'(s), 2'h3};
            wrchk(`IDX_DISP_TCLK, {24'hffffff, v}, v & 8'h3d);
            period(s == 1 ? 64 : fastDiv[d]);
         end
      end
      wrchk(`IDX_DISP_TCLK, 32'h80000030, 8'h30);
      quiet();
      fastOscOn <= 1'b0;
      wrchk(`IDX_DISP_TCLK, 32'h80000031, 8'h31);
      quiet();
      conclude();
   end
endmodule : clock_gen_regs_tb_top
`default_nettype wire
